// >>> logic/aobic_top.sv
// Overview of operation
// - each analog output emits the connector named by its source setting, 0, 2 and anything past 399 give 0 %.
// - the two-bit sign mode passes, takes magnitude, negates, or negates the magnitude.
// - each analog output has a filter time of 0 to 10000 ms in 1 ms steps, reset 0.
// - each analog output adds a signed 12-bit offset of -2048 to +2047 steps of 5.33 mV, reset 0.
// - output volts equal connector percent over 100 % times the scale in 0.01 V, reset 10.00 V.
// - each binary terminal drives the input function 2 to 68 that its setting names.
// - terminals 4 and 5 each hold three function slots, all driven by the one input.
// - with position control low digit 2 or 3, terminal 1 also resets the position counter.
// - changing an off-line setting raises a switch-on inhibit that needs acknowledgement.
// - function 53 raises the external fault only after its input stays low for the delay.
// - terminal 6 resets to function 5, fault acknowledge; the others reset to function 0.
`timescale 1ns/1ps
module aobic_top
    import aobic_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic [8:0] conn_addr_o,
    input wire logic [15:0] conn_data_i,
    output logic [15:0] aout3_code_o,
    output logic [15:0] aout4_code_o,
    input wire logic [NUM_BIN-1:0] bin_in_i,
    output logic [NUM_FUNC-1:0] func_o,
    output logic ext_fault_o,
    output logic pos_cnt_reset_o,
    output logic switch_on_inhibit_o,
    output logic irq_o
);

    // ****************************************
    // apb slave
    // ****************************************
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rdata_next;
    logic addr_ok;
    wire setup = ce_i && psel_i && !penable_i;
    wire wr_en = ce_i && psel_i && penable_i && pready_reg && pwrite_i;
    wire ao_sel = (paddr_i < (AO_STRIDE << 1));
    wire ao_ch = paddr_i[5];
    wire [7:0] ao_fld = paddr_i & (AO_STRIDE - 8'h01);
    wire slot_sel = (paddr_i >= BIN_SLOT_BASE) && (paddr_i < EXT_DELAY_ADDR);
    wire [7:0] slot_off = paddr_i - BIN_SLOT_BASE;
    wire [3:0] slot_idx = slot_off[5:2];
    wire slot_wr = wr_en && slot_sel && (slot_idx < 4'(NUM_SLOT));
    wire [13:0] wtime = (pwdata_i[13:0] > TIME_MAX_MS) ? TIME_MAX_MS : pwdata_i[13:0];

    // ****************************************
    // settings
    // ****************************************
    logic [8:0] src_reg [NUM_AOUT];
    logic [1:0] sign_reg [NUM_AOUT];
    logic [13:0] filt_reg [NUM_AOUT];
    logic [11:0] offs_reg [NUM_AOUT];
    logic [15:0] scale_reg [NUM_AOUT];
    logic [15:0] code_reg [NUM_AOUT];
    logic [31:0] y_reg [NUM_AOUT];
    logic [6:0] slot_reg [NUM_SLOT];
    logic [13:0] ext_delay_reg;
    logic [11:0] pos_ctrl_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_en_reg;
    logic inhibit_reg;

    genvar g;
    generate
        for (g = 0; g < NUM_AOUT; g++) begin : g_ao
            wire ch_wr = wr_en && ao_sel && (ao_ch == 1'(g));
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    src_reg[g] <= 9'h000;
                    sign_reg[g] <= 2'h0;
                    filt_reg[g] <= 14'h0000;
                    offs_reg[g] <= 12'h000;
                    scale_reg[g] <= SCALE_RST;
                end else if (ch_wr) begin
                    if (ao_fld == AO_SRC) src_reg[g] <= pwdata_i[8:0];
                    if (ao_fld == AO_SIGN) sign_reg[g] <= pwdata_i[1:0];
                    if (ao_fld == AO_FILT) filt_reg[g] <= wtime;
                    if (ao_fld == AO_OFFS) offs_reg[g] <= pwdata_i[11:0];
                    if (ao_fld == AO_SCALE) scale_reg[g] <= pwdata_i[15:0];
                end
            end
        end
        for (g = 0; g < NUM_SLOT; g++) begin : g_slot
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    slot_reg[g] <= (g == NUM_SLOT - 1) ? BIN6_FUNC_RST : FUNC_NONE;
                end else if (slot_wr && (slot_idx == 4'(g))) begin
                    slot_reg[g] <= pwdata_i[6:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_delay_reg <= 14'h0000;
            pos_ctrl_reg <= 12'h000;
            irq_en_reg <= '0;
        end else if (wr_en) begin
            if (paddr_i == EXT_DELAY_ADDR) ext_delay_reg <= wtime;
            if (paddr_i == POS_CTRL_ADDR) pos_ctrl_reg <= pwdata_i[11:0];
            if (paddr_i == IRQ_EN_ADDR) irq_en_reg <= pwdata_i[IRQ_W-1:0];
        end
    end

    always_comb begin
        addr_ok = 1'b1;
        rdata_next = 32'h0000_0000;
        if (ao_sel) begin
            case (ao_fld)
                AO_SRC: rdata_next = {23'h0, src_reg[ao_ch]};
                AO_SIGN: rdata_next = {30'h0, sign_reg[ao_ch]};
                AO_FILT: rdata_next = {18'h0, filt_reg[ao_ch]};
                AO_OFFS: rdata_next = {{20{offs_reg[ao_ch][11]}}, offs_reg[ao_ch]};
                AO_SCALE: rdata_next = {{16{scale_reg[ao_ch][15]}}, scale_reg[ao_ch]};
                AO_CODE: rdata_next = {{16{code_reg[ao_ch][15]}}, code_reg[ao_ch]};
                default: addr_ok = 1'b0;
            endcase
        end else if (slot_sel && (slot_idx < 4'(NUM_SLOT))) begin
            rdata_next = {25'h0, slot_reg[slot_idx]};
        end else begin
            case (paddr_i)
                EXT_DELAY_ADDR: rdata_next = {18'h0, ext_delay_reg};
                POS_CTRL_ADDR: rdata_next = {20'h0, pos_ctrl_reg};
                INHIBIT_ADDR: rdata_next = {31'h0, inhibit_reg};
                IRQ_STAT_ADDR: rdata_next = {29'h0, irq_stat_reg};
                IRQ_EN_ADDR: rdata_next = {29'h0, irq_en_reg};
                IRQ_CLR_ADDR: rdata_next = 32'h0000_0000;
                default: addr_ok = 1'b0;
            endcase
        end
    end

    // no wait state: answer data is fixed at the setup edge
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            pready_reg <= setup;
            if (setup) begin
                pslverr_reg <= !addr_ok;
                prdata_reg <= (pwrite_i || !addr_ok) ? 32'h0000_0000 : rdata_next;
            end
        end
    end

    // ****************************************
    // binary input functions
    // ****************************************
    logic [NUM_FUNC-1:0] func_reg;
    logic [NUM_FUNC-1:0] func_next;
    logic [NUM_SLOT-1:0] slot_low_ext;
    generate
        for (g = 0; g < NUM_FUNC; g++) begin : g_func
            logic [NUM_SLOT-1:0] hit;
            for (genvar s = 0; s < NUM_SLOT; s++) begin : g_hit
                assign hit[s] = (slot_reg[s] == 7'(g)) && bin_in_i[SLOT_TERM[s]];
            end
            // 0 is no function and 1 is reserved, so neither bit ever drives
            assign func_next[g] = (7'(g) >= FUNC_FIRST) && (|hit);
        end
        for (g = 0; g < NUM_SLOT; g++) begin : g_ext
            assign slot_low_ext[g] = (slot_reg[g] == FUNC_EXT_FAULT) && !bin_in_i[SLOT_TERM[g]];
        end
    endgenerate

    wire ext_low = |slot_low_ext;
    wire pos_digit_hit = (pos_ctrl_reg[3:0] == POS_RST_DIGIT_A)
                         || (pos_ctrl_reg[3:0] == POS_RST_DIGIT_B);
    wire pos_next = bin_in_i[0] && pos_digit_hit;
    wire ack_rise = func_next[FUNC_FAULT_ACK] && !func_reg[FUNC_FAULT_ACK];
    wire inh_clr = (wr_en && (paddr_i == INHIBIT_ADDR) && pwdata_i[0]) || ack_rise;

    // ****************************************
    // ms tick, external fault and inhibit
    // ****************************************
    logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_reg;
    wire tick_end = (tick_cnt_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
    logic tick_reg;
    logic [13:0] low_ms_reg;
    logic ext_fault_reg;
    logic pos_reg;
    wire ext_fault_next = ext_low && (low_ms_reg >= ext_delay_reg);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
            low_ms_reg <= 14'h0000;
            ext_fault_reg <= 1'b0;
            pos_reg <= 1'b0;
            func_reg <= '0;
            inhibit_reg <= 1'b0;
        end else if (ce_i) begin
            tick_reg <= tick_end;
            tick_cnt_reg <= tick_end ? '0 : tick_cnt_reg + 1'b1;
            // the low time counts whole ms ticks, so the delay may run up to one tick short
            if (!ext_low) begin
                low_ms_reg <= 14'h0000;
            end else if (tick_reg && (low_ms_reg < TIME_MAX_MS)) begin
                low_ms_reg <= low_ms_reg + 14'h0001;
            end
            ext_fault_reg <= ext_fault_next;
            pos_reg <= pos_next;
            func_reg <= func_next;
            // a new off-line write wins over an acknowledge in the same cycle
            if (slot_wr) begin
                inhibit_reg <= 1'b1;
            end else if (inh_clr) begin
                inhibit_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // interrupts
    // ****************************************
    logic irq_reg;
    wire [IRQ_W-1:0] irq_set = {pos_next && !pos_reg, slot_wr && !inhibit_reg,
                                ext_fault_next && !ext_fault_reg};
    wire [IRQ_W-1:0] irq_clr = (wr_en && (paddr_i == IRQ_CLR_ADDR)) ? pwdata_i[IRQ_W-1:0] : '0;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat_reg <= '0;
            irq_reg <= 1'b0;
        end else if (ce_i) begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
            irq_reg <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // ****************************************
    // analog output processing
    // ****************************************
    aobic_proc_t state_reg;
    logic ch_reg;
    logic [8:0] conn_addr_reg;
    logic [DIV_BITS-1:0] div_num_reg;
    logic [14:0] div_rem_reg;
    logic [4:0] div_cnt_reg;
    logic div_neg_reg;

    // source 0, 2 and anything past 399 read as a fixed 0 %
    wire [8:0] src = src_reg[ch_reg];
    wire src_zero = (src == SRC_ZERO_A) || (src == SRC_ZERO_B) || (src > SRC_MAX);
    wire [1:0] sgn = sign_reg[ch_reg];
    wire signed [16:0] x_raw = src_zero ? 17'sh00000 : 17'(signed'(conn_data_i));
    wire signed [16:0] x_mag = (sgn[0] && x_raw[16]) ? -x_raw : x_raw;
    wire signed [16:0] x_sgn = sgn[1] ? -x_mag : x_mag;
    wire signed [31:0] x_fix = 32'(x_sgn) <<< FIX_FRAC;
    wire signed [31:0] delta = x_fix - signed'(y_reg[ch_reg]);
    wire [31:0] delta_mag = delta[31] ? 32'(-delta) : 32'(delta);
    wire [13:0] tau = filt_reg[ch_reg];

    wire [14:0] rem_shift = {div_rem_reg[13:0], div_num_reg[DIV_BITS-1]};
    wire [15:0] rem_diff = {1'b0, rem_shift} - {2'b00, tau};
    wire rem_ge = !rem_diff[15];
    wire signed [31:0] quo = 32'(div_num_reg);
    wire signed [31:0] y_step = div_neg_reg ? -quo : quo;

    // volts*100 = y * scale / 16384; then 10 mV to 5.33 mV steps via 1921/1024
    wire signed [47:0] y_int = 48'(signed'(y_reg[ch_reg]) >>> FIX_FRAC);
    wire signed [47:0] volt100 = (y_int * 48'(signed'(scale_reg[ch_reg]))) >>> CONN_FULL_SHIFT;
    wire signed [47:0] lsb = (volt100 * 48'(signed'({1'b0, LSB_NUM}))) >>> LSB_SHIFT;
    wire signed [47:0] code_full = lsb + 48'(signed'(offs_reg[ch_reg]));
    wire code_hi = (code_full > 48'sh7FFF);
    wire code_lo = (code_full < -48'sh8000);
    wire [15:0] code_sat = code_hi ? 16'h7FFF : (code_lo ? 16'h8000 : code_full[15:0]);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= P_IDLE;
            ch_reg <= 1'b0;
            conn_addr_reg <= 9'h000;
            div_num_reg <= '0;
            div_rem_reg <= 15'h0000;
            div_cnt_reg <= 5'h00;
            div_neg_reg <= 1'b0;
            for (int i = 0; i < NUM_AOUT; i++) begin
                y_reg[i] <= 32'h0000_0000;
                code_reg[i] <= 16'h0000;
            end
        end else if (ce_i) begin
            case (state_reg)
                P_IDLE: begin
                    ch_reg <= 1'b0;
                    if (tick_reg) state_reg <= P_ADDR;
                end
                P_ADDR: begin
                    conn_addr_reg <= src;
                    state_reg <= P_WAIT;
                end
                P_WAIT: state_reg <= P_DATA;
                P_DATA: begin
                    if (tau == 14'h0000) begin
                        y_reg[ch_reg] <= x_fix;
                        div_cnt_reg <= 5'h00;
                        state_reg <= P_OUT;
                    end else begin
                        div_num_reg <= delta_mag[DIV_BITS-1:0];
                        div_neg_reg <= delta[31];
                        div_rem_reg <= 15'h0000;
                        div_cnt_reg <= 5'(DIV_BITS - 1);
                        state_reg <= P_DIV;
                    end
                end
                P_DIV: begin
                    // step of (x - y) / tau per ms gives a time constant of tau ms
                    div_rem_reg <= rem_ge ? rem_diff[14:0] : rem_shift;
                    div_num_reg <= {div_num_reg[DIV_BITS-2:0], rem_ge};
                    div_cnt_reg <= div_cnt_reg - 5'h01;
                    if (div_cnt_reg == 5'h00) state_reg <= P_OUT;
                end
                P_OUT: begin
                    if ((tau != 14'h0000) && (div_cnt_reg != 5'h00)) begin
                        y_reg[ch_reg] <= 32'(signed'(y_reg[ch_reg]) + y_step);
                        div_cnt_reg <= 5'h00;
                    end else begin
                        code_reg[ch_reg] <= code_sat;
                        ch_reg <= !ch_reg;
                        state_reg <= ch_reg ? P_IDLE : P_ADDR;
                    end
                end
                default: state_reg <= P_IDLE;
            endcase
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign conn_addr_o = conn_addr_reg;
    assign aout3_code_o = code_reg[0];
    assign aout4_code_o = code_reg[1];
    assign func_o = func_reg;
    assign ext_fault_o = ext_fault_reg;
    assign pos_cnt_reset_o = pos_reg;
    assign switch_on_inhibit_o = inhibit_reg;
    assign irq_o = irq_reg;

endmodule : aobic_top

// >>> logic/aobic_pkg.sv
package aobic_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int NUM_AOUT = 2;
    localparam int NUM_BIN = 6;
    localparam int NUM_SLOT = 10;
    localparam int NUM_FUNC = 69;
    localparam int DIV_BITS = 26;
    localparam int FIX_FRAC = 8;
    localparam int CONN_FULL_SHIFT = 14;
    localparam int LSB_SHIFT = 10;
    // terminal index served by each function slot (terminals 4 and 5 own three slots)
    localparam int SLOT_TERM [NUM_SLOT] = '{0, 1, 2, 3, 3, 3, 4, 4, 4, 5};

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 20000000;
    localparam int MS_PER_S = 1000;
    localparam int FILTER_STEP_MS = 1;
    localparam int TICK_CYCLES_DEF = CLK_HZ / MS_PER_S * FILTER_STEP_MS;

    // ****************************************
    // setting codes and limits
    // ****************************************
    localparam logic [8:0] SRC_ZERO_A = 9'h000;
    localparam logic [8:0] SRC_ZERO_B = 9'h002;
    localparam logic [8:0] SRC_MAX = 9'h18F;
    localparam logic [1:0] SIGN_ABS_BIT = 2'h1;
    localparam logic [1:0] SIGN_NEG_BIT = 2'h2;
    localparam logic [13:0] TIME_MAX_MS = 14'h2710;
    localparam logic [15:0] SCALE_RST = 16'h03E8;
    localparam logic [15:0] LSB_NUM = 16'h0781;
    localparam logic [6:0] FUNC_NONE = 7'h00;
    localparam logic [6:0] FUNC_FIRST = 7'h02;
    localparam logic [6:0] FUNC_FAULT_ACK = 7'h05;
    localparam logic [6:0] FUNC_EXT_FAULT = 7'h35;
    localparam logic [6:0] BIN6_FUNC_RST = FUNC_FAULT_ACK;
    localparam logic [3:0] POS_RST_DIGIT_A = 4'h2;
    localparam logic [3:0] POS_RST_DIGIT_B = 4'h3;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] AO_STRIDE = 8'h20;
    localparam logic [7:0] AO_SRC = 8'h00;
    localparam logic [7:0] AO_SIGN = 8'h04;
    localparam logic [7:0] AO_FILT = 8'h08;
    localparam logic [7:0] AO_OFFS = 8'h0C;
    localparam logic [7:0] AO_SCALE = 8'h10;
    localparam logic [7:0] AO_CODE = 8'h14;
    localparam logic [7:0] BIN_SLOT_BASE = 8'h40;
    localparam logic [7:0] EXT_DELAY_ADDR = 8'h70;
    localparam logic [7:0] POS_CTRL_ADDR = 8'h74;
    localparam logic [7:0] INHIBIT_ADDR = 8'h78;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h80;
    localparam logic [7:0] IRQ_EN_ADDR = 8'h84;
    localparam logic [7:0] IRQ_CLR_ADDR = 8'h88;

    // ****************************************
    // interrupt bits
    // ****************************************
    localparam int IRQ_W = 3;
    localparam int IRQ_EXT_FAULT = 0;
    localparam int IRQ_INHIBIT = 1;
    localparam int IRQ_POS_RST = 2;

    typedef enum logic [2:0] {
        P_IDLE,
        P_ADDR,
        P_WAIT,
        P_DATA,
        P_DIV,
        P_OUT
    } aobic_proc_t;

endpackage : aobic_pkg

// >>> sim/aobic_field_model.sv
`timescale 1ns/1ps
module aobic_field_model
    import aobic_pkg::*;
(
    input wire logic [8:0] conn_addr_i,
    input wire logic [NUM_BIN-1:0] bin_req_i,
    input wire logic armed_i,
    output logic [15:0] conn_data_o,
    output logic [NUM_BIN-1:0] bin_in_o
);
    // ****
    // connectors: 100 = +100 %, 101 = -50 %, the rest a ramp never at 0 %
    // ****
    wire logic [15:0] ramp = {7'h00, conn_addr_i} + 16'h0100;
    assign conn_data_o = (conn_addr_i == 9'h064) ? 16'h4000 :
        (conn_addr_i == 9'h065) ? 16'hE000 : ramp;
    // terminals stay de-energized until their functions are settled
    assign bin_in_o = armed_i ? bin_req_i : '0;
endmodule : aobic_field_model

// >>> sim/aobic_properties.sv
`timescale 1ns/1ps
module aobic_properties (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [5:0] bin_in_i,
    input wire logic [68:0] func_o,
    input wire logic ext_fault_o,
    input wire logic pos_cnt_reset_o,
    input wire logic switch_on_inhibit_o
);
    // ****
    // checks
    // ****
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence setup_s;
        psel_i && !penable_i && ce_i;
    endsequence
    sequence wr_s;
        pwrite_i && penable_i;
    endsequence
    a_ready_next: assert property (setup_s |=> pready_o)
        else $error("pready missing after setup");
    a_ready_single: assert property (pready_o && ce_i |=> !pready_o)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (setup_s ##0 paddr_i == 8'hFC |=> pslverr_o)
        else $error("no error on unmapped address");
    a_reserved_func: assert property (func_o[1:0] == 2'h0)
        else $error("reserved function active");
    a_func_cause: assert property (func_o != '0 |-> $past(bin_in_i) != '0)
        else $error("function without energized terminal");
    a_pos_cause: assert property (pos_cnt_reset_o |-> $past(bin_in_i[0]))
        else $error("position reset without terminal 1");
    a_fault_low: assert property ($rose(ext_fault_o) |-> $past(bin_in_i) != 6'h3F)
        else $error("fault with all terminals high");
    a_inhibit_set: assert property ($rose(switch_on_inhibit_o) |->
        $past(pwrite_i && penable_i) || $past(pwrite_i && penable_i, 2))
        else $error("inhibit without a write");
    a_inhibit_clear: assert property ($fell(switch_on_inhibit_o) |->
        $past(pwrite_i && penable_i) || $past(bin_in_i != '0) || $past(bin_in_i != '0, 2))
        else $error("inhibit dropped without cause");
    c_write: cover property (setup_s ##1 wr_s);
endmodule : aobic_properties
bind aobic_top aobic_properties u_props (.*);

// >>> sim/aobic_bench.sv
`timescale 1ns/1ps
module aobic_bench;
    import aobic_pkg::*;
    localparam int TICK = 100;
    logic mclk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, armed = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, err;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic pready_o, pslverr_o, ext_fault_o, pos_cnt_reset_o, switch_on_inhibit_o, irq_o;
    logic [8:0] conn_addr_o;
    logic [15:0] conn_data_i, aout3_code_o, aout4_code_o;
    logic [NUM_BIN-1:0] bin_in_i, bin_req = '1;
    logic [NUM_FUNC-1:0] fexp, func_o;
    int fails = 0;
    int tests_run = 0;
    always #25 mclk_i = ~mclk_i;
    aobic_top #(.TICK_CYCLES(TICK)) uut (.*);
    aobic_field_model field (.conn_addr_i(conn_addr_o), .bin_req_i(bin_req),
        .armed_i(armed), .conn_data_o(conn_data_i), .bin_in_o(bin_in_i));
    // ****
    // helpers
    // ****
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // rounding of the scaled code is not fixed, so allow two steps
    task automatic near(input string n, input int e, input logic [15:0] g);
        int d;
        tests_run++;
        d = int'($signed(g)) - e;
        if ($isunknown(g) || d > 2 || d < -2) begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, $signed(g));
        end
    endtask : near
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready_o});
        repeat (2) @(posedge mclk_i);
    endtask : apb
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rchk
    task automatic wait_ms(input int n);
        repeat (n * TICK) @(posedge mclk_i);
    endtask : wait_ms
    function automatic int code_of(input int x, input logic [1:0] m, input int s, input int o);
        int v;
        v = (m[0] && x < 0) ? -x : x;
        v = m[1] ? -v : v;
        return v * s / 16384 * 1921 / 1024 + o;
    endfunction : code_of
    // ****
    // scenarios
    // ****
    task automatic t_reset;
        rchk("scale3", AO_SCALE, 32'h3E8);
        rchk("scale4", AO_STRIDE + AO_SCALE, 32'h3E8);
        rchk("filter3", AO_FILT, 32'h0);
        rchk("offset4", AO_STRIDE + AO_OFFS, 32'h0);
        rchk("slot term6", BIN_SLOT_BASE + 8'h24, 32'h5);
        rchk("slot term1", BIN_SLOT_BASE, 32'h0);
        apb(1'b0, 8'hFC, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        chk("unmapped rd", 32'h0, rd);
        wait_ms(3);
        near("aout3 src0", 0, aout3_code_o);
    endtask : t_reset
    task automatic t_analog;
        apb(1'b1, AO_SRC, 32'd100);
        apb(1'b1, AO_STRIDE + AO_SRC, 32'd101);
        apb(1'b1, AO_STRIDE + AO_SCALE, 32'd500);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, AO_SIGN, 32'(m));
            apb(1'b1, AO_STRIDE + AO_SIGN, 32'(m));
            wait_ms(3);
            near("aout3", code_of(16384, 2'(m), 1000, 0), aout3_code_o);
            near("aout4", code_of(-8192, 2'(m), 500, 0), aout4_code_o);
        end
        apb(1'b1, AO_OFFS, 32'd2000);
        apb(1'b1, AO_STRIDE + AO_OFFS, 32'hFFFFF830);
        wait_ms(3);
        near("aout3 offs", code_of(16384, 2'h3, 1000, 2000), aout3_code_o);
        near("aout4 offs", code_of(-8192, 2'h3, 500, -2000), aout4_code_o);
        apb(1'b1, AO_SRC, 32'd2);
        wait_ms(3);
        near("aout3 src2", 2000, aout3_code_o);
    endtask : t_analog
    task automatic t_filter;
        logic ok;
        apb(1'b1, AO_OFFS, 32'h0);
        apb(1'b1, AO_SIGN, 32'h0);
        apb(1'b1, AO_FILT, 32'd5);
        wait_ms(3);
        apb(1'b1, AO_SRC, 32'd100);
        repeat (TICK * 5 / 2) @(posedge mclk_i);
        ok = $signed(aout3_code_o) > 200 && $signed(aout3_code_o) < 1300;
        chk("filter rise", 32'h1, {31'h0, ok});
        wait_ms(60);
        near("filter end", 1875, aout3_code_o);
        apb(1'b1, AO_FILT, 32'h0);
        apb(1'b1, AO_SRC, 32'd101);
        wait_ms(2);
        near("no filter", code_of(-8192, 2'h0, 1000, 0), aout3_code_o);
        apb(1'b1, AO_FILT, 32'h2EE0);
        rchk("filter clamp", AO_FILT, 32'h2710);
    endtask : t_filter
    task automatic t_binary;
        apb(1'b1, BIN_SLOT_BASE, 32'h0A);
        apb(1'b1, BIN_SLOT_BASE + 8'h0C, 32'h14);
        apb(1'b1, BIN_SLOT_BASE + 8'h10, 32'h15);
        apb(1'b1, BIN_SLOT_BASE + 8'h14, 32'h16);
        chk("held off", 32'h1, {31'h0, func_o === '0});
        chk("inhibit", 32'h1, {31'h0, switch_on_inhibit_o});
        rchk("irq stat", IRQ_STAT_ADDR, 32'h2);
        apb(1'b1, IRQ_EN_ADDR, 32'h2);
        chk("irq on", 32'h1, {31'h0, irq_o});
        apb(1'b1, IRQ_CLR_ADDR, 32'h2);
        chk("irq off", 32'h0, {31'h0, irq_o});
        apb(1'b1, INHIBIT_ADDR, 32'h1);
        chk("inhibit ack", 32'h0, {31'h0, switch_on_inhibit_o});
        bin_req <= 6'b101001;
        armed <= 1'b1;
        repeat (3) @(posedge mclk_i);
        fexp = '0;
        fexp[10] = 1'b1;
        fexp[22:20] = 3'h7;
        fexp[5] = 1'b1;
        chk("func all", 32'h1, {31'h0, func_o === fexp});
        bin_req <= 6'b001000;
        repeat (3) @(posedge mclk_i);
        fexp[10] = 1'b0;
        fexp[5] = 1'b0;
        chk("func term4", 32'h1, {31'h0, func_o === fexp});
    endtask : t_binary
    task automatic t_position;
        bin_req <= 6'h01;
        for (int d = 1; d < 4; d++) begin
            apb(1'b1, POS_CTRL_ADDR, 32'h010 | 32'(d));
            chk("pos reset", {31'h0, d >= 2}, {31'h0, pos_cnt_reset_o});
        end
    endtask : t_position
    task automatic t_fault;
        bin_req <= 6'h02;
        apb(1'b1, BIN_SLOT_BASE + 8'h04, 32'h35);
        apb(1'b1, EXT_DELAY_ADDR, 32'd3);
        wait_ms(2);
        chk("fault idle", 32'h0, {31'h0, ext_fault_o});
        bin_req <= 6'h00;
        repeat (TICK * 3 / 2) @(posedge mclk_i);
        chk("fault early", 32'h0, {31'h0, ext_fault_o});
        wait_ms(3);
        chk("fault late", 32'h1, {31'h0, ext_fault_o});
        apb(1'b0, IRQ_STAT_ADDR, 32'h0);
        chk("fault irq", 32'h1, {31'h0, rd[0]});
    endtask : t_fault
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (60000) @(posedge mclk_i);
        fails++;
        finish_test;
    end
    initial begin
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        t_reset;
        t_analog;
        t_filter;
        t_binary;
        t_position;
        t_fault;
        finish_test;
    end
endmodule : aobic_bench
